// ---- design/admx_pkg.sv ----
/*
 * Shared constants and types for the converter output demultiplexer.
 * Assumes one 40 MHz system clock; every pin-side input is synchronised in the core.
 */
package admx_pkg;
    localparam int          CLK_PERIOD_NS     = 25;
    localparam int          NUM_PORTS         = 4;
    localparam int          WORD_W            = 10;
    localparam int          SYNC_W            = 19;
    localparam logic [9:0]  WORD_ALL_HIGH     = 10'h3ff;
    localparam logic [9:0]  WORD_ALL_LOW      = 10'h000;
    localparam logic [9:0]  CHECK_EVEN_WORD   = 10'h2aa;
    localparam logic [9:0]  CHECK_ODD_WORD    = 10'h155;
    localparam logic [1:0]  LAST_PORT_RATIO4  = 2'h3;
    localparam logic [1:0]  LAST_PORT_RATIO2  = 2'h1;
    // Register byte offsets
    localparam logic [3:0]  OFS_CTRL          = 4'h0;
    localparam logic [3:0]  OFS_STATUS        = 4'h4;
    localparam logic [3:0]  OFS_OVR_COUNT     = 4'h8;
    // Control register fields
    localparam int          CTRL_REALIGN_BIT  = 0;
    // Status register fields
    localparam int          STAT_MODE_LSB     = 0;
    localparam int          STAT_PHASE_LSB    = 8;
    localparam int          STAT_WPHASE_BIT   = 10;
    localparam int          STAT_STATE_LSB    = 12;
    localparam logic [31:0] RESET_WORD        = 32'h0000_0000;
    localparam logic [15:0] OVR_COUNT_RESET   = 16'h0000;
    // Mode field positions inside the synchronised mode vector
    localparam int          MODE_CTYPE_BIT    = 0;
    localparam int          MODE_RATIO_BIT    = 1;
    localparam int          MODE_TEST_N_BIT   = 2;
    localparam int          MODE_TIMING_N_BIT = 3;
    localparam int          MODE_SLEEP_N_BIT  = 4;

    typedef enum logic [2:0] {
        ADMX_ST_ALIGN = 3'h1,
        ADMX_ST_RUN   = 3'h2,
        ADMX_ST_SLEEP = 3'h4
    } admx_state_type;
endpackage : admx_pkg

// ---- design/admx_regs_if.sv ----
/*
 * Carrier between the demultiplexer core and its register slave.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface admx_regs_if;
    logic                  realign_req;
    logic                  ovr_event;
    logic [4:0]            mode_bits;
    logic [1:0]            phase;
    logic                  word_phase;
    admx_pkg::admx_state_type state;

    modport core (output ovr_event, output mode_bits, output phase, output word_phase, output state,
                  input realign_req);
    modport regs (input ovr_event, input mode_bits, input phase, input word_phase, input state,
                  output realign_req);
endinterface : admx_regs_if

// ---- design/admx_avalon_regs.sv ----
/*
 * Avalon-MM register slave of the output demultiplexer.
 * Assumes a master that holds its request until it samples waitrequest low.
 */
`timescale 1ns/100ps
module admx_avalon_regs (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    admx_regs_if.regs        rif
);
    logic [15:0] ovr_count_reg;
    logic        realign_reg;
    logic        req;
    logic        accept;
    logic [31:0] status_word;

    assign req    = avs_read | avs_write;
    // Accepted at the edge where the master sees waitrequest low
    assign accept = req & ~avs_waitrequest;
    assign rif.realign_req = realign_reg;

    always_comb begin
        status_word = admx_pkg::RESET_WORD;
        status_word[admx_pkg::STAT_MODE_LSB +: 5]  = rif.mode_bits;
        status_word[admx_pkg::STAT_PHASE_LSB +: 2] = rif.phase;
        status_word[admx_pkg::STAT_WPHASE_BIT]     = rif.word_phase;
        status_word[admx_pkg::STAT_STATE_LSB +: 3] = rif.state;
    end

    // One wait cycle, then a single ready cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~(req & avs_waitrequest);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            avs_readdata <= admx_pkg::RESET_WORD;
        end else if (avs_read && avs_waitrequest) begin
            case (avs_address)
                admx_pkg::OFS_STATUS:    avs_readdata <= status_word;
                admx_pkg::OFS_OVR_COUNT: avs_readdata <= {16'h0000, ovr_count_reg};
                default:                 avs_readdata <= admx_pkg::RESET_WORD;
            endcase
        end
    end

    // Self-clearing realign request
    always_ff @(posedge clk) begin
        if (rst) begin
            realign_reg <= 1'b0;
        end else begin
            realign_reg <= accept && avs_write && (avs_address == admx_pkg::OFS_CTRL)
                           && avs_writedata[admx_pkg::CTRL_REALIGN_BIT];
        end
    end

    // A new event in the clearing cycle is kept: set wins
    always_ff @(posedge clk) begin
        if (rst) begin
            ovr_count_reg <= admx_pkg::OVR_COUNT_RESET;
        end else if (accept && avs_write && (avs_address == admx_pkg::OFS_OVR_COUNT)) begin
            ovr_count_reg <= {15'h0000, rif.ovr_event};
        end else if (rif.ovr_event && (ovr_count_reg != 16'hffff)) begin
            ovr_count_reg <= ovr_count_reg + 16'h0001;
        end
    end
endmodule : admx_avalon_regs

// ---- design/admx_demux.sv ----
/*
 * Output demultiplexer core: spreads converter samples over two or four output
 * ports, forwards data-ready clocks, drives out-of-range bits, checkerboard test.
 * Assumes sample_clk and all pin inputs are asynchronous to clk and far slower
 * (sample_clk period at least 8 clk periods), and that sample data and range
 * flags are stable for two clk periods either side of a sample_clk rising edge.
 */
// Summary of operation
// - Sleep, port-timing and test selects are active low, idle high.
// - Ratio select low spreads samples over two ports, high over four.
// - Full-rate clock is a quarter of sample rate in four-port mode, rising centred.
// - Half-rate clock is an eighth of sample rate in four-port mode, toggling per word.
// - Clock-type input high selects full-rate clocking, low selects half-rate.
// - Staggered mode presents port words one after another, simultaneous all at once.
// - Simultaneous output by default; staggered only while port-timing select is low.
// - In staggered mode each overrange pin carries that port's data-ready clock.
// - In simultaneous mode the overrange bit is one on overflow or underflow.
// - Positive overrange forces all ones, negative forces all zeros, overrange bit set.
// - Main clock equals port B clock in two-port mode, port D in four-port.
// - Sleep select low parks outputs; high resumes normal conversion.
// - Self-test words are checkerboards that invert on every new output word.
// - Demultiplexer reset is applied before self-test for a deterministic phase.
// - Four-port test sequence 2AA,155,2AA,155 then 155,2AA,155,2AA; overrange marks 155.
// - Two-port test sequence 2AA,155 then 155,2AA; overrange marks 155.
// - Demultiplexer reset aligns order so samples go to ports A, B, C, D in four-port mode, A, B in two-port.
// - Demultiplexer reset input is active high.
`timescale 1ns/100ps
module admx_demux (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             sample_clk,
    input  wire logic [9:0]       sample_data,
    input  wire logic             sample_overflow,
    input  wire logic             sample_underflow,
    input  wire logic             demux_async_reset,
    input  wire logic             sleep_select_n,
    input  wire logic             port_timing_select_n,
    input  wire logic             checkerboard_test_select_n,
    input  wire logic             port_ratio_select,
    input  wire logic             forwarded_clock_type,
    input  wire logic [3:0]       avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [31:0]      avs_writedata,
    output logic      [31:0]      avs_readdata,
    output logic                  avs_waitrequest,
    output logic      [3:0][9:0]  port_data,
    output logic      [3:0]       port_overrange_or_clock,
    output logic                  main_forwarded_clock
);
    logic [admx_pkg::SYNC_W-1:0] sync1_reg;
    logic [admx_pkg::SYNC_W-1:0] sync2_reg;
    logic                        sclk_prev_reg;
    logic [4:0]                  mode_prev_reg;
    logic [4:0]                  mode_s;
    logic                        sclk_s;
    logic                        dreset_s;
    logic [9:0]                  data_s;
    logic                        over_s;
    logic                        under_s;
    logic                        tick;
    logic                        mode_chg;
    logic                        realign;
    logic                        stag_on;
    logic                        test_on;
    logic                        ratio4;
    logic                        full_rate;
    logic [1:0]                  last;
    admx_pkg::admx_state_type    state_reg;
    admx_pkg::admx_state_type    state_next;
    logic [1:0]                  cnt_reg;
    logic [1:0]                  cnt_next;
    logic                        wphase_reg;
    logic [3:0][9:0]             shadow_reg;
    logic [3:0]                  shadow_or_reg;
    logic [3:0]                  port_clk_reg;
    logic [3:0]                  clk_next;
    logic [9:0]                  cur_word;
    logic                        cur_or;
    logic                        check_sel;
    logic                        running_tick;
    admx_regs_if                 rif ();

    function automatic logic [1:0] admx_pos(input logic [1:0] cnt, input logic [1:0] k,
                                            input logic [1:0] lst);
        admx_pos = (cnt - k - 2'h1) & lst;
    endfunction : admx_pos

    // Two flip-flops on every pin input before any logic reads it
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {sample_clk, demux_async_reset, sleep_select_n, port_timing_select_n,
                          checkerboard_test_select_n, port_ratio_select, forwarded_clock_type,
                          sample_overflow, sample_underflow, sample_data};
            sync2_reg <= sync1_reg;
        end
    end

    assign sclk_s   = sync2_reg[18];
    assign dreset_s = sync2_reg[17];
    assign mode_s   = sync2_reg[16:12];
    assign over_s   = sync2_reg[11];
    assign under_s  = sync2_reg[10];
    assign data_s   = sync2_reg[9:0];

    // Low level asserts the port-timing and test selects; ratio and clock-type selects are active high
    assign stag_on   = ~mode_s[admx_pkg::MODE_TIMING_N_BIT];
    assign test_on   = ~mode_s[admx_pkg::MODE_TEST_N_BIT];
    assign ratio4    = mode_s[admx_pkg::MODE_RATIO_BIT];
    assign full_rate = mode_s[admx_pkg::MODE_CTYPE_BIT];
    assign last      = ratio4 ? admx_pkg::LAST_PORT_RATIO4 : admx_pkg::LAST_PORT_RATIO2;

    always_ff @(posedge clk) begin
        if (rst) begin
            sclk_prev_reg <= 1'b0;
            mode_prev_reg <= 5'h1f;
        end else begin
            sclk_prev_reg <= sclk_s;
            mode_prev_reg <= mode_s;
        end
    end

    assign tick     = sclk_s & ~sclk_prev_reg;
    // A mode change mid-word would scramble the port order, so it realigns
    assign mode_chg = (mode_s != mode_prev_reg);
    assign realign  = dreset_s | rif.realign_req | mode_chg;
    assign running_tick = tick && (state_reg == admx_pkg::ADMX_ST_RUN) && !realign;

    always_comb begin
        case (state_reg)
            admx_pkg::ADMX_ST_ALIGN: state_next = admx_pkg::ADMX_ST_RUN;
            admx_pkg::ADMX_ST_RUN:   state_next = mode_s[admx_pkg::MODE_SLEEP_N_BIT] ?
                                                  admx_pkg::ADMX_ST_RUN : admx_pkg::ADMX_ST_SLEEP;
            admx_pkg::ADMX_ST_SLEEP: state_next = mode_s[admx_pkg::MODE_SLEEP_N_BIT] ?
                                                  admx_pkg::ADMX_ST_ALIGN : admx_pkg::ADMX_ST_SLEEP;
            default:                 state_next = admx_pkg::ADMX_ST_ALIGN;
        endcase
        if (realign) begin
            state_next = admx_pkg::ADMX_ST_ALIGN;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= admx_pkg::ADMX_ST_ALIGN;
        end else begin
            state_reg <= state_next;
        end
    end

    assign cnt_next = (cnt_reg == last) ? 2'h0 : cnt_reg + 2'h1;

    // Port pointer and word phase restart at port A, even word
    always_ff @(posedge clk) begin
        if (rst || realign || state_reg != admx_pkg::ADMX_ST_RUN) begin
            cnt_reg    <= 2'h0;
            wphase_reg <= 1'b0;
        end else if (tick) begin
            cnt_reg <= cnt_next;
            if (cnt_reg == last) begin
                wphase_reg <= ~wphase_reg;
            end
        end
    end

    // Checkerboard alternates per sample and inverts per word
    assign check_sel = cnt_reg[0] ^ wphase_reg;

    always_comb begin
        if (test_on) begin
            cur_word = check_sel ? admx_pkg::CHECK_ODD_WORD : admx_pkg::CHECK_EVEN_WORD;
            cur_or   = check_sel;
        end else if (over_s) begin
            cur_word = admx_pkg::WORD_ALL_HIGH;
            cur_or   = 1'b1;
        end else if (under_s) begin
            cur_word = admx_pkg::WORD_ALL_LOW;
            cur_or   = 1'b1;
        end else begin
            cur_word = data_s;
            cur_or   = 1'b0;
        end
    end

    // Port clock position counts ticks since that port last loaded
    always_comb begin
        logic [1:0] keff;
        logic [1:0] p;
        logic       dr;
        logic       at_half;
        keff    = 2'h0;
        p       = 2'h0;
        dr      = 1'b0;
        at_half = 1'b0;
        for (int k = 0; k < admx_pkg::NUM_PORTS; k++) begin
            keff    = stag_on ? k[1:0] : last;
            p       = admx_pos(cnt_next, keff, last);
            dr      = ratio4 ? p[1] : p[0];
            at_half = ratio4 ? (p == 2'h2) : (p == 2'h1);
            if (k[1:0] > last) begin
                clk_next[k] = 1'b0;
            end else if (full_rate) begin
                clk_next[k] = dr;
            end else begin
                clk_next[k] = port_clk_reg[k] ^ at_half;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst || state_reg != admx_pkg::ADMX_ST_RUN || realign) begin
            shadow_reg    <= '0;
            shadow_or_reg <= 4'h0;
        end else if (tick) begin
            shadow_reg[cnt_reg]    <= cur_word;
            shadow_or_reg[cnt_reg] <= cur_or;
        end
    end

    // Parked outputs in sleep and while aligning; the level is not meaningful
    always_ff @(posedge clk) begin
        if (rst || state_reg != admx_pkg::ADMX_ST_RUN || realign) begin
            port_data               <= '0;
            port_overrange_or_clock <= 4'h0;
            port_clk_reg            <= 4'h0;
            main_forwarded_clock    <= 1'b0;
        end else if (tick) begin
            port_clk_reg         <= clk_next;
            main_forwarded_clock <= clk_next[last];
            if (stag_on) begin
                port_data[cnt_reg]      <= cur_word;
                port_overrange_or_clock <= clk_next;
            end else if (cnt_reg == last) begin
                for (int k = 0; k < admx_pkg::NUM_PORTS; k++) begin
                    if (k[1:0] == cnt_reg) begin
                        port_data[k]               <= cur_word;
                        port_overrange_or_clock[k] <= cur_or;
                    end else if (k[1:0] < cnt_reg) begin
                        port_data[k]               <= shadow_reg[k];
                        port_overrange_or_clock[k] <= shadow_or_reg[k];
                    end
                end
            end
        end
    end

    assign rif.ovr_event  = running_tick && cur_or && !test_on;
    assign rif.mode_bits  = mode_s;
    assign rif.phase      = cnt_reg;
    assign rif.word_phase = wphase_reg;
    assign rif.state      = state_reg;

    admx_avalon_regs u_regs (
        .clk             (clk),
        .rst             (rst),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .rif             (rif)
    );

    a_ratio_two_ports: assert property (@(posedge clk) disable iff (rst)
        (!ratio4 && !mode_chg) |-> !cnt_reg[1])
        else $error("Two-port ratio reached port C or D");
    a_pointer_wraps: assert property (@(posedge clk) disable iff (rst)
        (running_tick && cnt_reg == last) |=> (cnt_reg == 2'h0))
        else $error("Port pointer did not wrap to port A");
    a_full_rate_clock: assert property (@(posedge clk) disable iff (rst)
        (state_reg == admx_pkg::ADMX_ST_RUN && full_rate && ratio4 && !mode_chg)
        |-> (main_forwarded_clock == cnt_reg[1]))
        else $error("Full-rate clock not high in second half of word");
    a_half_rate_toggle: assert property (@(posedge clk) disable iff (rst)
        (running_tick && !full_rate && ratio4 && cnt_reg == 2'h1)
        |=> (main_forwarded_clock != $past(main_forwarded_clock)))
        else $error("Half-rate clock did not toggle mid-word");
    a_half_rate_hold: assert property (@(posedge clk) disable iff (rst)
        (running_tick && !full_rate && ratio4 && cnt_reg != 2'h1)
        |=> $stable(main_forwarded_clock))
        else $error("Half-rate clock toggled off mid-word");
    a_stagger_load: assert property (@(posedge clk) disable iff (rst)
        (running_tick && stag_on) |=> (port_data[$past(cnt_reg)] == $past(cur_word)))
        else $error("Staggered port did not take its sample");
    a_simul_hold: assert property (@(posedge clk) disable iff (rst)
        (running_tick && !stag_on && cnt_reg != last) |=> $stable(port_data))
        else $error("Simultaneous ports changed before the word completed");
    a_or_is_clock: assert property (@(posedge clk) disable iff (rst)
        (running_tick && stag_on) |=> (port_overrange_or_clock == port_clk_reg))
        else $error("Staggered overrange pins do not carry port clocks");
    a_overflow_word: assert property (@(posedge clk) disable iff (rst)
        (running_tick && !stag_on && !test_on && over_s && cnt_reg == last)
        |=> (port_data[$past(cnt_reg)] == admx_pkg::WORD_ALL_HIGH)
            && port_overrange_or_clock[$past(cnt_reg)])
        else $error("Overflow word or bit wrong");
    a_main_equals_last: assert property (@(posedge clk) disable iff (rst)
        (running_tick && stag_on) |=> (main_forwarded_clock == port_overrange_or_clock[last]))
        else $error("Main clock differs from last port clock");
    a_sleep_parked: assert property (@(posedge clk) disable iff (rst)
        (state_reg == admx_pkg::ADMX_ST_SLEEP) |=> (port_data == '0) && !main_forwarded_clock)
        else $error("Outputs not parked during sleep");
    a_checker_word: assert property (@(posedge clk) disable iff (rst)
        (running_tick && stag_on && test_on)
        |=> (port_data[$past(cnt_reg)] == ($past(check_sel) ? admx_pkg::CHECK_ODD_WORD
                                                             : admx_pkg::CHECK_EVEN_WORD)))
        else $error("Checkerboard word wrong for port and phase");
    a_realign_order: assert property (@(posedge clk) disable iff (rst)
        dreset_s |=> (state_reg == admx_pkg::ADMX_ST_ALIGN) && (cnt_reg == 2'h0) && !wphase_reg)
        else $error("Reset did not realign to port A");

    c_stagger_word: cover property (@(posedge clk) disable iff (rst)
        running_tick && stag_on && ratio4 && cnt_reg == 2'h3);
    c_test_run: cover property (@(posedge clk) disable iff (rst)
        running_tick && test_on && wphase_reg && cnt_reg == last);
    c_sleep_entry: cover property (@(posedge clk) disable iff (rst)
        state_reg == admx_pkg::ADMX_ST_SLEEP);
    c_overrange: cover property (@(posedge clk) disable iff (rst)
        running_tick && !stag_on && cur_or && !test_on);
endmodule : admx_demux

// ---- testbench/admx_rx_model.sv ----
/*
 * Receiver model: captures the port words on each rising edge of the main
 * forwarded clock, as a receiving FPGA would.
 * Assumes it runs on the core clock and sees the core's registered outputs.
 */
`timescale 1ns/100ps
module admx_rx_model (
    input  wire logic            clk,
    input  wire logic [3:0][9:0] port_data,
    input  wire logic            main_forwarded_clock,
    output logic      [3:0][9:0] cap_words,
    output logic                 cap_overflow
);
    logic clk_d_reg = 1'b0;
    always_ff @(posedge clk) begin
        clk_d_reg <= main_forwarded_clock;
        if (main_forwarded_clock && !clk_d_reg) begin
            cap_words    <= port_data;
            // Overflow seen as an all-ones word on port B, no range bit needed
            cap_overflow <= (port_data[1] == 10'h3ff);
        end
    end
endmodule : admx_rx_model

// ---- testbench/admx_demux_tb.sv ----
/*
 * Self-checking bench of the output demultiplexer core.
 * Assumes the core's hand-over timing: one Avalon wait cycle, 3-4 clk sample latency.
 */
`timescale 1ns/100ps
module admx_demux_tb;
    logic            clk = 1'b0, rst = 1'b1, sclk = 1'b0, ovf = 1'b0, unf = 1'b0, arst = 1'b0;
    logic            ratio = 1'b1, test_n = 1'b1, rdq = 1'b0, wrq = 1'b0, waitq, mclk, cov;
    logic            stag_n = 1'b1, ctype = 1'b1, sleep_n = 1'b1;
    logic [9:0]      sd = 10'h000;
    logic [3:0]      addr = 4'h0, ovr;
    logic [31:0]     wdat = 32'h0, rdata, r;
    logic [3:0][9:0] pd, cap, e;
    int              err_total = 0, samples_checked = 0;
    always #12.5 clk = ~clk;
    admx_demux i_dut (.clk(clk), .rst(rst), .sample_clk(sclk), .sample_data(sd),
        .sample_overflow(ovf), .sample_underflow(unf), .demux_async_reset(arst),
        .sleep_select_n(sleep_n), .port_timing_select_n(stag_n), .checkerboard_test_select_n(test_n),
        .port_ratio_select(ratio), .forwarded_clock_type(ctype), .avs_address(addr),
        .avs_read(rdq), .avs_write(wrq), .avs_writedata(wdat), .avs_readdata(rdata),
        .avs_waitrequest(waitq), .port_data(pd), .port_overrange_or_clock(ovr),
        .main_forwarded_clock(mclk));
    admx_rx_model i_rx (.clk(clk), .port_data(pd), .main_forwarded_clock(mclk),
        .cap_words(cap), .cap_overflow(cov));
    task automatic summarize;
        if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        addr <= a;
        wdat <= wd;
        rdq  <= !wr;
        wrq  <= wr;
        do @(posedge clk); while (waitq !== 1'b0);
        rd = rdata;
        rdq <= 1'b0;
        wrq <= 1'b0;
    endtask : bus
    // Data stays put four clk either side of the rising sample edge; clock keeps running in
    task automatic smp(input logic [9:0] d, input logic o, input logic u);
        sd  <= d;
        ovf <= o;
        unf <= u;
        repeat (4) @(posedge clk);
        sclk <= 1'b1;
        repeat (4) @(posedge clk);
        sclk <= 1'b0;
    endtask : smp
    task automatic mode(input logic rs, input logic tn);
        ratio  <= rs;
        test_n <= tn;
        repeat (8) @(posedge clk);
        arst <= 1'b1;
        repeat (4) @(posedge clk);
        arst <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : mode
    task automatic run_simultaneous;
        mode(1'b1, 1'b1);
        smp(10'h011, 1'b0, 1'b0);
        smp(10'h123, 1'b1, 1'b0);
        smp(10'h0a5, 1'b0, 1'b1);
        smp(10'h2c3, 1'b0, 1'b0);
        repeat (2) @(posedge clk);
        chk(pd, {10'h2c3, 10'h000, 10'h3ff, 10'h011});
        chk({36'h0, ovr}, 40'h6);
        repeat (3) smp(10'h000, 1'b0, 1'b0);
        repeat (4) @(posedge clk);
        chk(cap, {10'h2c3, 10'h000, 10'h3ff, 10'h011});
        chk({39'h0, cov}, 40'h1);
    endtask : run_simultaneous
    // Staggered half-rate: each port clock toggles once per word, then sleep parks outputs
    task automatic run_stagger;
        stag_n <= 1'b0;
        ctype  <= 1'b0;
        mode(1'b1, 1'b1);
        for (int w = 0; w < 2; w++) begin
            for (int p = 0; p < 4; p++) smp(10'h101 + 10'(p), 1'b0, 1'b0);
            repeat (2) @(posedge clk);
            chk(pd, {10'h104, 10'h103, 10'h102, 10'h101});
            chk({35'h0, mclk, ovr}, {35'h0, w == 0, {4{w == 0}}});
        end
        sleep_n <= 1'b0;
        repeat (8) @(posedge clk);
        smp(10'h3ff, 1'b1, 1'b0);
        chk({35'h0, mclk, ovr}, 40'h0);
        chk(pd, 40'h0);
        sleep_n <= 1'b1;
        stag_n  <= 1'b1;
        ctype   <= 1'b1;
    endtask : run_stagger
    task automatic run_regs;
        bus(1'b0, 4'h8, 32'h0, r);
        chk({24'h0, r[15:0]}, 40'h2);
        bus(1'b1, 4'h8, 32'h0, r);
        bus(1'b0, 4'h8, 32'h0, r);
        chk({8'h0, r}, 40'h0);
        bus(1'b0, 4'h4, 32'h0, r);
        chk({8'h0, r & 32'h701f}, 40'h201f);
        bus(1'b0, 4'hc, 32'h0, r);
        chk({8'h0, r}, 40'h0);
    endtask : run_regs
    // Checkerboard in both ratios, two words each so the inversion shows
    task automatic run_selftest(input logic rs);
        int n;
        n = rs ? 4 : 2;
        mode(rs, 1'b0);
        for (int w = 0; w < 2; w++) begin
            repeat (n) smp(10'h000, 1'b0, 1'b0);
            repeat (2) @(posedge clk);
            e = '0;
            for (int p = 0; p < n; p++) e[p] = ((p % 2) != w) ? 10'h155 : 10'h2aa;
            chk(pd, e);
            for (int p = 0; p < n; p++) chk({39'h0, ovr[p]}, {39'h0, e[p] == 10'h155});
        end
    endtask : run_selftest
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        run_simultaneous();
        run_regs();
        run_stagger();
        run_selftest(1'b1);
        run_selftest(1'b0);
        summarize();
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        summarize();
    end
endmodule : admx_demux_tb
